//--- verilog/wwdt_defs.svh
// Purpose: Constants for the windowed watchdog timer.
// Assumes: Included by the package, the prescaler, the timer and the bench; the synchroniser does not include it.
// Notes: Offsets are byte addresses on the plain register port.
`ifndef WWDT_DEFS_SVH
`define WWDT_DEFS_SVH
`define WWDT_ADDR_W 8
`define WWDT_OFS_RESTART 8'h00
`define WWDT_OFS_MODE 8'h04
`define WWDT_OFS_STATUS 8'h08
`define WWDT_KEY 8'hA5
`define WWDT_KEY_MSB 31
`define WWDT_KEY_LSB 24
`define WWDT_RESTART_BIT 0
`define WWDT_MODE_RESET 32'h3FFF_2FFF
`define WWDT_MODE_MASK 32'h3FFF_FFFF
`define WWDT_ZERO32 32'h0000_0000
`define WWDT_STAT_PAD 30'h0000_0000
`define WWDT_PRESCALE 128
`define WWDT_CNT_W 12
`define WWDT_CNT_ZERO 12'h000
`define WWDT_CNT_ONE 12'h001
`define WWDT_CNT_RESET 12'hFFF
`endif

//--- verilog/wwdt_pkg.sv
// Purpose: Types shared by the windowed watchdog timer files.
// Assumes: wwdt_defs.svh supplies the widths.
// Notes: Mode layout matches the register bit order, bit 31 first.
`include "wwdt_defs.svh"
package wwdt_pkg;
   typedef struct packed {
      logic [1:0] reserved;
      logic idle_halt;
      logic debug_halt;
      logic [`WWDT_CNT_W-1:0] delta_window_value;
      logic timer_disable;
      logic processor_reset_only;
      logic fault_reset_enable;
      logic fault_interrupt_enable;
      logic [`WWDT_CNT_W-1:0] counter_reload_value;
   } wwdt_mode_t;

   typedef struct packed {
      logic window_error_flag;
      logic underflow_flag;
   } wwdt_status_t;
endpackage : wwdt_pkg

//--- verilog/wwdt_sync.sv
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous levels.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module wwdt_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule : wwdt_sync

//--- verilog/wwdt_prescaler.sv
// Purpose: Divides slow clock edges into one counter tick per DIV edges.
// Assumes: slow_tick is a one-cycle pulse per slow clock rising edge.
// Notes: restart clears the divider and suppresses that cycle's tick.
`timescale 1ns/1ps
`include "wwdt_defs.svh"
module wwdt_prescaler #(
   parameter int DIV = `WWDT_PRESCALE
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic slow_tick,
   input wire logic restart,
   output logic tick
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] div_q;
   logic [CW-1:0] div_d;
   logic tick_q;
   logic tick_d;

   always_comb begin
      div_d = div_q;
      tick_d = 1'b0;
      if (restart) begin
         div_d = '0;
      end else if (slow_tick) begin
         if (div_q == LAST) begin
            div_d = '0;
            tick_d = 1'b1;
         end else begin
            div_d = div_q + CW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_div_wrap;
      (div_q == LAST) && slow_tick && !restart |=> tick_q && (div_q == '0);
   endproperty
   a_div_wrap: assert property (p_div_wrap) else $error("prescaler did not wrap");

   property p_div_restart;
      restart |=> (div_q == '0) && !tick_q;
   endproperty
   a_div_restart: assert property (p_div_restart) else $error("prescaler not restarted");
endmodule : wwdt_prescaler

//--- verilog/wwdt_timer.sv
// Purpose: Windowed watchdog with keyed restart, write-once mode, clear-on-read status.
// Assumes: slow_clk, debug_state and idle_mode are asynchronous pin levels.
// Notes: resetn is the processor reset; it reopens the mode register.
`timescale 1ns/1ps
`include "wwdt_defs.svh"
// Contract
// - A keyed restart write with restart bit one restarts; zero does nothing.
// - Restart writes whose upper byte is not the key are ignored entirely.
// - Counter reload value field loads the 12-bit counter on restart or reprogram.
// - Interrupt enable one lets faults raise the interrupt; zero keeps it low.
// - Reset enable one lets faults request reset; zero leaves resets alone.
// - Fault asserts all resets, or only processor reset when that select is set.
// - Restart reloads only while counter is at or below the delta value.
// - Restart while counter exceeds delta is a window error, not a restart.
// - Debug halt set stops counting during debug state; clear keeps running.
// - Idle halt set stops counting during idle mode; clear keeps running.
// - Timer disable set stops the watchdog; clear enables it.
// - Underflow flag sets on underflow and holds until status is read.
// - Window error flag sets on error and holds until status is read.
// - Mode register takes one write after reset and resets to its default.
// - Counter ticks every 128 slow clocks; restart also restarts that divider.
// - Status read or reset clears flags, interrupt and fault signal.
// - Mode write reloads and restarts counter; only processor reset reopens it.
// - Underflow sets its flag and, if reset enabled, asserts the fault signal.
module wwdt_timer #(
   parameter int PRESCALE = `WWDT_PRESCALE
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [`WWDT_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic slow_clk,
   input wire logic debug_state,
   input wire logic idle_mode,
   output logic wdt_irq,
   output logic wdt_fault,
   output logic rst_all_req,
   output logic rst_proc_req
);
   // Pin levels after synchronisation
   logic [2:0] pins_sync;
   logic slow_s;
   logic debug_s;
   logic idle_s;
   logic slow_prev_q;
   logic slow_prev_d;
   logic slow_edge;
   logic tick;

   // Register and counter state
   wwdt_pkg::wwdt_mode_t mode_q;
   wwdt_pkg::wwdt_mode_t mode_d;
   wwdt_pkg::wwdt_status_t stat_q;
   wwdt_pkg::wwdt_status_t stat_d;
   logic mode_locked_q;
   logic mode_locked_d;
   logic [`WWDT_CNT_W-1:0] cnt_q;
   logic [`WWDT_CNT_W-1:0] cnt_d;
   logic fault_q;
   logic fault_d;
   logic irq_q;
   logic irq_d;
   logic rst_all_q;
   logic rst_all_d;
   logic rst_proc_q;
   logic rst_proc_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // Decoded events
   logic key_ok;
   logic wr_restart;
   logic wr_mode;
   logic rd_status;
   logic restart_ok;
   logic restart_err;
   logic reload;
   logic halted;
   logic run;
   logic underflow;

   function automatic logic addr_hit(input logic [`WWDT_ADDR_W-1:0] a,
                                     input logic [`WWDT_ADDR_W-1:0] ofs);
      addr_hit = (a == ofs);
   endfunction : addr_hit

   wwdt_sync #(
      .W(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in({slow_clk, debug_state, idle_mode}),
      .sync_out(pins_sync)
   );

   assign slow_s = pins_sync[2];
   assign debug_s = pins_sync[1];
   assign idle_s = pins_sync[0];
   assign slow_edge = slow_s && !slow_prev_q;

   wwdt_prescaler #(
      .DIV(PRESCALE)
   ) u_prescaler (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .slow_tick(slow_edge),
      .restart(reload),
      .tick(tick)
   );

   // Register access decode
   always_comb begin
      key_ok = (reg_wdata[`WWDT_KEY_MSB:`WWDT_KEY_LSB] == `WWDT_KEY);
      wr_restart = reg_wr && addr_hit(reg_addr, `WWDT_OFS_RESTART) && key_ok
                   && reg_wdata[`WWDT_RESTART_BIT];
      wr_mode = reg_wr && addr_hit(reg_addr, `WWDT_OFS_MODE) && !mode_locked_q;
      rd_status = reg_rd && addr_hit(reg_addr, `WWDT_OFS_STATUS);
      restart_ok = wr_restart && (cnt_q <= mode_q.delta_window_value);
      restart_err = wr_restart && (cnt_q > mode_q.delta_window_value);
      reload = restart_ok || wr_mode;
      halted = (debug_s && mode_q.debug_halt) || (idle_s && mode_q.idle_halt);
      run = !mode_q.timer_disable && !halted;
      // A reload in the same cycle wins over the tick, so no underflow is taken
      underflow = run && tick && !reload && (cnt_q == `WWDT_CNT_ZERO);
   end

   // Mode register and counter
   always_comb begin
      slow_prev_d = slow_s;
      mode_d = mode_q;
      mode_locked_d = mode_locked_q;
      cnt_d = cnt_q;
      if (wr_mode) begin
         mode_d = wwdt_pkg::wwdt_mode_t'(reg_wdata & `WWDT_MODE_MASK);
         mode_locked_d = 1'b1;
      end
      if (wr_mode) begin
         cnt_d = mode_d.counter_reload_value;
      end else if (restart_ok) begin
         cnt_d = mode_q.counter_reload_value;
      end else if (run && tick) begin
         if (cnt_q == `WWDT_CNT_ZERO) begin
            cnt_d = mode_q.counter_reload_value;
         end else begin
            cnt_d = cnt_q - `WWDT_CNT_ONE;
         end
      end
   end

   // Status flags and fault outputs; a new event wins over the read clear
   always_comb begin
      stat_d.underflow_flag = underflow || (stat_q.underflow_flag && !rd_status);
      stat_d.window_error_flag = restart_err
                                 || (stat_q.window_error_flag && !rd_status);
      fault_d = (mode_q.fault_reset_enable && (underflow || restart_err))
                || (fault_q && !rd_status);
      irq_d = mode_q.fault_interrupt_enable
              && (stat_d.underflow_flag || stat_d.window_error_flag);
      rst_all_d = fault_d && !mode_q.processor_reset_only;
      rst_proc_d = fault_d && mode_q.processor_reset_only;
   end

   // Read data, valid only in the cycle after the read strobe
   always_comb begin
      rdata_d = `WWDT_ZERO32;
      if (reg_rd && addr_hit(reg_addr, `WWDT_OFS_MODE)) begin
         rdata_d = mode_q;
      end else if (rd_status) begin
         rdata_d = {`WWDT_STAT_PAD, stat_q};
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         slow_prev_q <= 1'b0;
         mode_q <= wwdt_pkg::wwdt_mode_t'(`WWDT_MODE_RESET);
         mode_locked_q <= 1'b0;
         cnt_q <= `WWDT_CNT_RESET;
         stat_q <= '0;
         fault_q <= 1'b0;
         irq_q <= 1'b0;
         rst_all_q <= 1'b0;
         rst_proc_q <= 1'b0;
         rdata_q <= `WWDT_ZERO32;
      end else begin
         slow_prev_q <= slow_prev_d;
         mode_q <= mode_d;
         mode_locked_q <= mode_locked_d;
         cnt_q <= cnt_d;
         stat_q <= stat_d;
         fault_q <= fault_d;
         irq_q <= irq_d;
         rst_all_q <= rst_all_d;
         rst_proc_q <= rst_proc_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign wdt_irq = irq_q;
   assign wdt_fault = fault_q;
   assign rst_all_req = rst_all_q;
   assign rst_proc_req = rst_proc_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_restart_reload;
      restart_ok && !wr_mode |=> cnt_q == $past(mode_q.counter_reload_value);
   endproperty
   a_restart_reload: assert property (p_restart_reload) else $error("restart did not reload");

   property p_zero_bit;
      reg_wr && addr_hit(reg_addr, `WWDT_OFS_RESTART) && !reg_wdata[`WWDT_RESTART_BIT]
      && !underflow |=> stat_q.window_error_flag == $past(stat_q.window_error_flag);
   endproperty
   a_zero_bit: assert property (p_zero_bit) else $error("zero restart bit acted");

   property p_bad_key;
      reg_wr && addr_hit(reg_addr, `WWDT_OFS_RESTART) && !key_ok
      |=> stat_q.window_error_flag == $past(stat_q.window_error_flag);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("keyless restart write acted");

   property p_window_err;
      wr_restart && (cnt_q > mode_q.delta_window_value)
      |=> stat_q.window_error_flag && (($past(run) && $past(tick))
          ? cnt_q == $past(cnt_q) - `WWDT_CNT_ONE : $stable(cnt_q));
   endproperty
   a_window_err: assert property (p_window_err) else $error("early restart not an error");

   property p_unf_flag;
      underflow |=> stat_q.underflow_flag && cnt_q == $past(mode_q.counter_reload_value);
   endproperty
   a_unf_flag: assert property (p_unf_flag) else $error("underflow not flagged");

   property p_unf_fault;
      underflow && mode_q.fault_reset_enable |=> wdt_fault;
   endproperty
   a_unf_fault: assert property (p_unf_fault) else $error("underflow fault missing");

   property p_read_clear;
      rd_status && !underflow && !restart_err
      |=> !stat_q.underflow_flag && !stat_q.window_error_flag && !wdt_fault && !wdt_irq;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

   property p_irq_gate;
      $stable(mode_q) |-> wdt_irq == (mode_q.fault_interrupt_enable
                                      && (stat_q.underflow_flag || stat_q.window_error_flag));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

   property p_reset_select;
      $stable(mode_q) |-> (rst_proc_req == (wdt_fault && mode_q.processor_reset_only))
                          && (rst_all_req == (wdt_fault && !mode_q.processor_reset_only));
   endproperty
   a_reset_select: assert property (p_reset_select) else $error("reset select wrong");

   property p_no_rst_en;
      !mode_q.fault_reset_enable && !wdt_fault |=> !wdt_fault;
   endproperty
   a_no_rst_en: assert property (p_no_rst_en) else $error("fault without reset enable");

   property p_mode_once;
      mode_locked_q && reg_wr && addr_hit(reg_addr, `WWDT_OFS_MODE) |=> $stable(mode_q);
   endproperty
   a_mode_once: assert property (p_mode_once) else $error("mode written twice");

   property p_stopped;
      !run && !reload |=> $stable(cnt_q);
   endproperty
   a_stopped: assert property (p_stopped) else $error("halted counter moved");

   property p_decrement;
      run && tick && !reload && (cnt_q != `WWDT_CNT_ZERO) |=> cnt_q == $past(cnt_q) - `WWDT_CNT_ONE;
   endproperty
   a_decrement: assert property (p_decrement) else $error("counter did not decrement");

   property p_halt_idle;
      idle_s && mode_q.idle_halt && !reload |=> $stable(cnt_q);
   endproperty
   a_halt_idle: assert property (p_halt_idle) else $error("idle halt let counter move");

   property p_err_hold;
      stat_q.window_error_flag && !rd_status |=> stat_q.window_error_flag;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag dropped early");

   property p_unf_hold;
      stat_q.underflow_flag && !rd_status |=> stat_q.underflow_flag;
   endproperty
   a_unf_hold: assert property (p_unf_hold) else $error("underflow flag dropped early");

   // Mode write stores the masked word, locks, and reloads the counter from it
   property p_mode_write;
      wr_mode |=> mode_locked_q && (mode_q == ($past(reg_wdata) & `WWDT_MODE_MASK))
      && (cnt_q == mode_q.counter_reload_value);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write did not reload");

   c_underflow: cover property (underflow ##1 wdt_fault);
   c_window_err: cover property (restart_err ##1 stat_q.window_error_flag);
   c_restart_ok: cover property (restart_ok);
   c_read_clear: cover property (stat_q.underflow_flag && rd_status ##1 !stat_q.underflow_flag);
endmodule : wwdt_timer

//--- tb/wwdt_rstc_model.sv
// Purpose: Reset controller stand-in that answers watchdog reset requests.
// Assumes: Requests are levels from the watchdog, synchronous to sys_clk.
// Notes: With apply low it only listens, so faults stay visible at the pins.
`timescale 1ns/1ps
module wwdt_rstc_model (
   input wire logic sys_clk,
   input wire logic rst_all_req,
   input wire logic rst_proc_req,
   input wire logic apply,
   output logic rc_resetn
);
   logic [1:0] hold_q = 2'h0;
   logic req_q = 1'b0;
   assign rc_resetn = (hold_q == 2'h0);
   always @(posedge sys_clk) begin
      req_q <= rst_all_req | rst_proc_req;
      // Either request pulls the processor reset for three cycles
      if (apply && (rst_all_req || rst_proc_req) && !req_q) begin
         hold_q <= 2'h3;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
   end
endmodule : wwdt_rstc_model

//--- tb/tb.sv
// Purpose: Self-checking bench for the windowed watchdog timer.
// Assumes: PRESCALE of 2 and a slow clock of one eighth of sys_clk keep runs short.
// Notes: Rows cover fault routing and halts; hand tests cover restarts and resets.
`timescale 1ns/1ps
`include "wwdt_defs.svh"
module tb;
   typedef struct packed {
      logic [31:0] mode;
      logic dbg;
      logic idl;
      logic unf;
      logic irq;
      logic all;
      logic prc;
   } wwdt_row_t;
   logic sys_clk = 1'b0;
   logic tb_rstn = 1'b0;
   logic resetn;
   logic rc_resetn;
   logic apply = 1'b0;
   logic [`WWDT_ADDR_W-1:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic slow_clk = 1'b0;
   logic debug_state = 1'b0;
   logic idle_mode = 1'b0;
   logic wdt_irq;
   logic wdt_fault;
   logic rst_all_req;
   logic rst_proc_req;
   int n_fail = 0;
   int n_tests = 0;
   logic [31:0] rd_val;
   wwdt_row_t rows [8];
   assign resetn = tb_rstn & rc_resetn;

   wwdt_timer #(.PRESCALE(2)) u_wwdt_timer (.sys_clk(sys_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .slow_clk(slow_clk), .debug_state(debug_state),
      .idle_mode(idle_mode), .wdt_irq(wdt_irq), .wdt_fault(wdt_fault),
      .rst_all_req(rst_all_req), .rst_proc_req(rst_proc_req));
   wwdt_rstc_model u_wwdt_rstc_model (.sys_clk(sys_clk), .rst_all_req(rst_all_req),
      .rst_proc_req(rst_proc_req), .apply(apply), .rc_resetn(rc_resetn));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      forever begin
         repeat (4) @(posedge sys_clk);
         slow_clk <= ~slow_clk;
      end
   end

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Irq, fault, all-reset and processor-reset levels as one nibble
   task automatic outs(input logic [3:0] e);
      chk({28'h0, wdt_irq, wdt_fault, rst_all_req, rst_proc_req}, {28'h0, e});
   endtask : outs

   task automatic wait_cy(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_cy

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic do_reset();
      @(posedge sys_clk);
      tb_rstn <= 1'b0;
      repeat (10) @(posedge sys_clk);
      tb_rstn <= 1'b1;
   endtask : do_reset

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      give_verdict();
   end

   initial begin
      // Reload 2 underflows on the third tick, 40 to 55 cycles after the mode write
      rows = '{'{32'h0002_3002, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0},
               '{32'h0002_6002, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
               '{32'h0002_1002, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
               '{32'h0002_0002, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0},
               '{32'h0002_B002, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
               '{32'h1002_3002, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
               '{32'h0002_3002, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
               '{32'h2002_3002, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}};
      do_reset();
      wait_cy(1);
      outs(4'h0);
      rd(`WWDT_OFS_MODE, rd_val);
      chk(rd_val, 32'h3FFF_2FFF);
      rd(`WWDT_OFS_STATUS, rd_val);
      chk(rd_val, 32'h0000_0000);
      rd(8'h0C, rd_val);
      chk(rd_val, 32'h0000_0000);
      rd(`WWDT_OFS_RESTART, rd_val);
      chk(rd_val, 32'h0000_0000);
      foreach (rows[i]) begin
         @(posedge sys_clk);
         debug_state <= rows[i].dbg;
         idle_mode <= rows[i].idl;
         do_reset();
         wr(`WWDT_OFS_MODE, rows[i].mode);
         wait_cy(30);
         outs(4'h0);
         wait_cy(40);
         outs({rows[i].irq, rows[i].all | rows[i].prc, rows[i].all, rows[i].prc});
         rd(`WWDT_OFS_STATUS, rd_val);
         chk(rd_val, {31'h0, rows[i].unf});
         outs(4'h0);
      end
      @(posedge sys_clk);
      debug_state <= 1'b0;
      idle_mode <= 1'b0;
      do_reset();
      wr(`WWDT_OFS_MODE, 32'h0005_3003);
      wr(`WWDT_OFS_MODE, 32'h0001_0001);
      rd(`WWDT_OFS_MODE, rd_val);
      chk(rd_val, 32'h0005_3003);
      repeat (6) begin
         wr(`WWDT_OFS_RESTART, 32'hA500_0001);
         wait_cy(25);
      end
      outs(4'h0);
      wait_cy(80);
      outs(4'hE);
      rd(`WWDT_OFS_STATUS, rd_val);
      chk(rd_val, 32'h0000_0001);
      do_reset();
      wr(`WWDT_OFS_MODE, 32'h0001_3005);
      wr(`WWDT_OFS_RESTART, 32'h5A00_0001);
      wr(`WWDT_OFS_RESTART, 32'hA500_0000);
      wait_cy(2);
      outs(4'h0);
      wr(`WWDT_OFS_RESTART, 32'hA500_0001);
      wait_cy(2);
      outs(4'hE);
      rd(`WWDT_OFS_STATUS, rd_val);
      chk(rd_val, 32'h0000_0002);
      do_reset();
      apply <= 1'b1;
      wr(`WWDT_OFS_MODE, 32'h0001_6005);
      wr(`WWDT_OFS_RESTART, 32'hA500_0001);
      wait_cy(10);
      outs(4'h0);
      rd(`WWDT_OFS_MODE, rd_val);
      chk(rd_val, 32'h3FFF_2FFF);
      rd(`WWDT_OFS_STATUS, rd_val);
      chk(rd_val, 32'h0000_0000);
      wr(`WWDT_OFS_MODE, 32'h0001_3005);
      rd(`WWDT_OFS_MODE, rd_val);
      chk(rd_val, 32'h0001_3005);
      apply <= 1'b0;
      give_verdict();
   end
endmodule : tb
